// *** inc/scr_pkg.sv ***
// Constants and types shared by the system control register bank
package scr_pkg;
    // Register addresses on the plain register port
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_CTRL_C = 3'h2;
    localparam logic [2:0] ADDR_WAKE = 3'h3;
    localparam logic [2:0] ADDR_PULL_A = 3'h4;
    localparam logic [2:0] ADDR_PULL_B = 3'h5;
    localparam logic [2:0] ADDR_LCD_COM = 3'h6;
    // Reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h8A;
    localparam logic [7:0] CTRL_C_RST = 8'h01;
    localparam logic [7:0] AUX_RST = 8'h00;
    // Implemented bits of the third control register
    localparam logic [7:0] CTRL_C_MASK = 8'h11;
    // First control register fields
    localparam int A_PIN_ROUTE = 7;
    localparam int A_DIV_SRC = 6;
    localparam int A_PWM_SPLIT = 5;
    localparam int A_PWM1_EN = 4;
    localparam int A_PWM0_EN = 3;
    localparam int A_DIV_OUT_EN = 2;
    localparam int A_XTAL_LP = 1;
    localparam int A_SLOW_SEL = 0;
    // Second control register fields
    localparam int B_EDGE_HI = 7;
    localparam int B_EDGE_LO = 6;
    localparam int B_TB_HI = 5;
    localparam int B_TB_LO = 4;
    localparam int B_WDT_HI = 3;
    localparam int B_WDT_LO = 0;
    // Third control register fields
    localparam int C_PWM2_EN = 4;
    localparam int C_XTAL_KEEP = 0;
    // Watchdog code that turns the watchdog off
    localparam logic [3:0] WDT_OFF_CODE = 4'hA;
    // Shortest time-base period exponent
    localparam logic [3:0] TB_BASE_EXP = 4'hA;

    // External interrupt trigger modes
    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } scr_edge_t;

    // Time-base period as a power of two of the timer clock
    function automatic logic [3:0] scr_tb_exp(input logic [1:0] code);
        scr_tb_exp = TB_BASE_EXP + {2'h0, code};
    endfunction : scr_tb_exp
endpackage : scr_pkg

// *** logic/scr_edge_detect.sv ***
// External interrupt synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none
module scr_edge_detect
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Pin and trigger mode
    input wire logic pin_i,
    input wire logic [1:0] mode_i,
    // Trigger pulse
    output logic edge_o
);
    logic sync1;
    logic sync2;
    logic prev;
    scr_edge_t mode;
    logic rise;
    logic fall;
    logic next_edge;

    // Edge terms from the synchronised samples only
    assign mode = scr_edge_t'(mode_i);
    assign rise = sync2 & ~prev;
    assign fall = ~sync2 & prev;

    // Trigger selection by mode
    always_comb
    begin
        case (mode)
            EDGE_OFF: next_edge = 1'b0;
            EDGE_RISE: next_edge = rise;
            EDGE_FALL: next_edge = fall;
            EDGE_BOTH: next_edge = rise | fall;
            default: next_edge = 1'b0;
        endcase
    end

    // Two-stage synchroniser and history
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            edge_o <= 1'b0;
        end
        else
        begin
            sync1 <= pin_i;
            sync2 <= sync1;
            prev <= sync2;
            edge_o <= next_edge;
        end
    end
endmodule : scr_edge_detect
`default_nettype wire

// *** logic/scr_control_regs.sv ***
// System control register bank with pin routing and clock controls
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module scr_control_regs
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    // Configuration options
    input wire logic cfg_rc_xtal_i,
    input wire logic cfg_wdt_on_i,
    input wire logic cfg_ext_rc_i,
    // Power state and pins
    input wire logic halt_i,
    input wire logic [7:0] port_a_i,
    input wire logic [7:0] port_a_dir_in_i,
    input wire logic [7:0] port_b_dir_in_i,
    input wire logic port_b5_i,
    input wire logic port_b4_i,
    input wire logic divider_i,
    // Pin routing
    output logic ext_irq_o,
    output logic timer0_input_o,
    output logic div_on_pa1_o,
    output logic div_on_pb3_o,
    output logic [2:0] pwm_out_en_o,
    output logic pwm_split_o,
    output logic divider_clock_src_o,
    // Clock and power control
    output logic sysclk_slow_o,
    output logic fast_rc_stop_o,
    output logic fast_clk_run_o,
    output logic slow_xtal_low_power_o,
    output logic slow_xtal_run_o,
    output logic tp_clk_from_sys_o,
    output logic [3:0] timebase_exp_o,
    output logic watchdog_enable_o,
    // Wake, pull-high, LCD commons, oscillator pins
    output logic wake_o,
    output logic [7:0] pull_a_o,
    output logic [7:0] pull_b_o,
    output logic [3:0] lcd_com_en_o,
    output logic pa6_osc_o,
    output logic pa5_io_free_o
);
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] wake_sel;
    logic [7:0] pull_a;
    logic [7:0] pull_b;
    logic [7:0] lcd_ctrl;
    logic [7:0] pa_prev;
    logic [7:0] next_rd_data;
    logic route_b;
    logic irq_pin;
    logic eff_slow;
    logic any_pwm;
    logic wake_hit;
    logic edge_pulse;
    logic wr_a;
    logic wr_b;
    logic wr_c;
    logic wr_wake;
    logic wr_pa;
    logic wr_pb;
    logic wr_lcd;

    // Write decode
    assign wr_a = wr_i && addr_i == ADDR_CTRL_A;
    assign wr_b = wr_i && addr_i == ADDR_CTRL_B;
    assign wr_c = wr_i && addr_i == ADDR_CTRL_C;
    assign wr_wake = wr_i && addr_i == ADDR_WAKE;
    assign wr_pa = wr_i && addr_i == ADDR_PULL_A;
    assign wr_pb = wr_i && addr_i == ADDR_PULL_B;
    assign wr_lcd = wr_i && addr_i == ADDR_LCD_COM;

    // Read selection, unmapped addresses read zero
    always_comb
    begin
        case (addr_i)
            ADDR_CTRL_A: next_rd_data = ctrl_a;
            ADDR_CTRL_B: next_rd_data = ctrl_b;
            ADDR_CTRL_C: next_rd_data = ctrl_c & CTRL_C_MASK;
            ADDR_WAKE: next_rd_data = wake_sel;
            ADDR_PULL_A: next_rd_data = pull_a;
            ADDR_PULL_B: next_rd_data = pull_b;
            ADDR_LCD_COM: next_rd_data = lcd_ctrl;
            default: next_rd_data = 8'h00;
        endcase
    end

    // Register storage
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_a <= CTRL_A_RST;
            ctrl_b <= CTRL_B_RST;
            ctrl_c <= CTRL_C_RST;
            wake_sel <= AUX_RST;
            pull_a <= AUX_RST;
            pull_b <= AUX_RST;
            lcd_ctrl <= AUX_RST;
        end
        else
        begin
            if (wr_a)
                ctrl_a <= wr_data_i;
            if (wr_b)
                ctrl_b <= wr_data_i;
            if (wr_c)
                ctrl_c <= wr_data_i & CTRL_C_MASK;
            if (wr_wake)
                wake_sel <= wr_data_i;
            if (wr_pa)
                pull_a <= wr_data_i;
            if (wr_pb)
                pull_b <= wr_data_i;
            if (wr_lcd)
                lcd_ctrl <= wr_data_i;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= rd_i ? next_rd_data : 8'h00;
    end

    // Shared routing and clock terms
    assign route_b = ctrl_a[A_PIN_ROUTE];
    assign irq_pin = route_b ? port_b5_i : port_a_i[3];
    assign eff_slow = ctrl_a[A_SLOW_SEL] & cfg_rc_xtal_i;
    assign any_pwm = ctrl_a[A_PWM0_EN] | ctrl_a[A_PWM1_EN]
        | ctrl_c[C_PWM2_EN];
    assign wake_hit = |(wake_sel & pa_prev & ~port_a_i);

    // Interrupt pin synchroniser and trigger
    scr_edge_detect u_edge
    (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(irq_pin),
        .mode_i(ctrl_b[B_EDGE_HI:B_EDGE_LO]),
        .edge_o(edge_pulse)
    );

    // Pin routing outputs
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            ext_irq_o <= 1'b0;
            timer0_input_o <= 1'b0;
            div_on_pa1_o <= 1'b0;
            div_on_pb3_o <= 1'b0;
            pwm_out_en_o <= 3'h0;
            pwm_split_o <= 1'b0;
            divider_clock_src_o <= 1'b0;
        end
        else
        begin
            ext_irq_o <= edge_pulse;
            timer0_input_o <= route_b ? port_b4_i : port_a_i[2];
            div_on_pa1_o <= ~route_b & ctrl_a[A_DIV_OUT_EN] & divider_i;
            div_on_pb3_o <= route_b & ctrl_a[A_DIV_OUT_EN] & divider_i;
            pwm_out_en_o <= {ctrl_c[C_PWM2_EN], ctrl_a[A_PWM1_EN],
                ctrl_a[A_PWM0_EN]};
            pwm_split_o <= ctrl_a[A_PWM_SPLIT];
            divider_clock_src_o <= ctrl_a[A_DIV_SRC];
        end
    end

    // Clock, power and watchdog outputs
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            sysclk_slow_o <= 1'b0;
            fast_rc_stop_o <= 1'b0;
            fast_clk_run_o <= 1'b0;
            slow_xtal_low_power_o <= 1'b0;
            slow_xtal_run_o <= 1'b0;
            tp_clk_from_sys_o <= 1'b0;
            timebase_exp_o <= TB_BASE_EXP;
            watchdog_enable_o <= 1'b1;
        end
        else
        begin
            sysclk_slow_o <= eff_slow;
            fast_rc_stop_o <= eff_slow | halt_i;
            fast_clk_run_o <= ~eff_slow & ~halt_i;
            slow_xtal_low_power_o <= ctrl_a[A_XTAL_LP] & cfg_rc_xtal_i;
            slow_xtal_run_o <= ~halt_i | ctrl_c[C_XTAL_KEEP];
            tp_clk_from_sys_o <= any_pwm;
            timebase_exp_o <= scr_tb_exp(ctrl_b[B_TB_HI:B_TB_LO]);
            watchdog_enable_o <= cfg_wdt_on_i
                | (ctrl_b[B_WDT_HI:B_WDT_LO] != WDT_OFF_CODE);
        end
    end

    // Wake, pull-high, LCD and oscillator pin outputs
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            pa_prev <= 8'hFF;
            wake_o <= 1'b0;
            pull_a_o <= 8'h00;
            pull_b_o <= 8'h00;
            lcd_com_en_o <= 4'h0;
            pa6_osc_o <= 1'b0;
            pa5_io_free_o <= 1'b0;
        end
        else
        begin
            pa_prev <= port_a_i;
            wake_o <= halt_i & wake_hit;
            pull_a_o <= pull_a & port_a_dir_in_i;
            pull_b_o <= pull_b & port_b_dir_in_i;
            lcd_com_en_o <= lcd_ctrl[3:0];
            pa6_osc_o <= cfg_ext_rc_i;
            pa5_io_free_o <= cfg_ext_rc_i;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_wr_a_zero;
        wr_a && wr_data_i == 8'h00;
    endsequence

    sequence s_wr_c_full;
        wr_c && wr_data_i == 8'hFF;
    endsequence

    chk_route_moves_div: assert property (
        ctrl_a[A_PIN_ROUTE] && ctrl_a[A_DIV_OUT_EN] && divider_i
        && !wr_a |=> div_on_pb3_o && !div_on_pa1_o)
        else $error("divider not on routed pin");

    chk_split_follow: assert property (
        s_wr_a_zero |=> ##1 !pwm_split_o)
        else $error("pwm split not following register");

    chk_pwm_tp_clock: assert property (
        ctrl_a[A_PWM0_EN] || ctrl_a[A_PWM1_EN] || ctrl_c[C_PWM2_EN]
        |=> tp_clk_from_sys_o)
        else $error("timer clock not system while pwm on");

    chk_wdt_off_code: assert property (
        wr_b && wr_data_i[3:0] == WDT_OFF_CODE && !cfg_wdt_on_i
        ##1 !wr_b && !cfg_wdt_on_i |=> !watchdog_enable_o)
        else $error("watchdog not off for off code");

    chk_wdt_forced: assert property (
        cfg_wdt_on_i |=> watchdog_enable_o)
        else $error("watchdog option ignored");

    chk_ctrl_c_unused: assert property (
        s_wr_c_full ##1 !wr_i ##1 rd_i && addr_i == ADDR_CTRL_C
        |=> rd_data_o == CTRL_C_MASK)
        else $error("unused bits not zero");

    chk_fast_clk_halt: assert property (
        halt_i |=> !fast_clk_run_o && fast_rc_stop_o)
        else $error("fast clock running in halt");

    chk_clk_mode_gate: assert property (
        !cfg_rc_xtal_i |=> !sysclk_slow_o && !slow_xtal_low_power_o)
        else $error("clock mode honoured without option");

    chk_wake_edge: assert property (
        halt_i && wake_sel[0] && !wr_wake ##1 !port_a_i[0] && halt_i
        && $past(port_a_i[0]) |=> wake_o)
        else $error("falling edge did not wake");

    chk_tb_period: assert property (
        wr_b && wr_data_i[5:4] == 2'b11 ##1 !wr_b
        |=> timebase_exp_o == 4'hD)
        else $error("time base period wrong");

    chk_read_slot: assert property (
        !rd_i |=> rd_data_o == 8'h00)
        else $error("read data outside its slot");
endmodule : scr_control_regs
`default_nettype wire

// *** dv/tb_scr_control_regs.sv ***
// Self-checking bench for the system control register bank
`timescale 1ns/100ps
`default_nettype none
module tb_scr_control_regs
    import scr_pkg::*;
;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cfg_rc_xtal_i = 1'b1;
    logic cfg_wdt_on_i = 1'b0;
    logic cfg_ext_rc_i = 1'b0;
    logic halt_i = 1'b0;
    logic [7:0] port_a_i = 8'h00;
    logic [7:0] port_a_dir_in_i = 8'h00;
    logic [7:0] port_b_dir_in_i = 8'h00;
    logic port_b5_i = 1'b0;
    logic port_b4_i = 1'b0;
    logic divider_i = 1'b0;
    logic [7:0] rd_data_o;
    logic ext_irq_o, timer0_input_o, div_on_pa1_o, div_on_pb3_o;
    logic [2:0] pwm_out_en_o;
    logic pwm_split_o, divider_clock_src_o, sysclk_slow_o, fast_rc_stop_o;
    logic fast_clk_run_o, slow_xtal_low_power_o, slow_xtal_run_o;
    logic tp_clk_from_sys_o, watchdog_enable_o, wake_o, pa6_osc_o;
    logic pa5_io_free_o;
    logic [3:0] timebase_exp_o, lcd_com_en_o;
    logic [7:0] pull_a_o, pull_b_o, rdv;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int irq_cnt = 0;
    int wake_cnt = 0;

    // Device under test
    scr_control_regs dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .cfg_rc_xtal_i(cfg_rc_xtal_i),
        .cfg_wdt_on_i(cfg_wdt_on_i), .cfg_ext_rc_i(cfg_ext_rc_i),
        .halt_i(halt_i), .port_a_i(port_a_i),
        .port_a_dir_in_i(port_a_dir_in_i), .port_b_dir_in_i(port_b_dir_in_i),
        .port_b5_i(port_b5_i), .port_b4_i(port_b4_i), .divider_i(divider_i),
        .ext_irq_o(ext_irq_o), .timer0_input_o(timer0_input_o),
        .div_on_pa1_o(div_on_pa1_o), .div_on_pb3_o(div_on_pb3_o),
        .pwm_out_en_o(pwm_out_en_o), .pwm_split_o(pwm_split_o),
        .divider_clock_src_o(divider_clock_src_o),
        .sysclk_slow_o(sysclk_slow_o), .fast_rc_stop_o(fast_rc_stop_o),
        .fast_clk_run_o(fast_clk_run_o),
        .slow_xtal_low_power_o(slow_xtal_low_power_o),
        .slow_xtal_run_o(slow_xtal_run_o),
        .tp_clk_from_sys_o(tp_clk_from_sys_o),
        .timebase_exp_o(timebase_exp_o),
        .watchdog_enable_o(watchdog_enable_o), .wake_o(wake_o),
        .pull_a_o(pull_a_o), .pull_b_o(pull_b_o),
        .lcd_com_en_o(lcd_com_en_o), .pa6_osc_o(pa6_osc_o),
        .pa5_io_free_o(pa5_io_free_o));

    // Clock, 4 ns period
    initial
    begin
        forever #2 mclk_i = ~mclk_i;
    end

    // Pulse counters and hang guard
    always @(posedge mclk_i)
    begin
        cycles = cycles + 1;
        if (ext_irq_o === 1'b1) irq_cnt = irq_cnt + 1;
        if (wake_o === 1'b1) wake_cnt = wake_cnt + 1;
        if (cycles == 20000)
        begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        checked = checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        // Take read data mid-cycle, while it stands
        @(negedge mclk_i);
        d = rd_data_o;
        @(posedge mclk_i);
    endtask : rd

    task automatic settle();
        // Ends on an edge; outputs stable since two edges
        repeat (3) @(posedge mclk_i);
    endtask : settle

    // Reset values of registers and outputs
    task automatic t_reset();
        logic [7:0] exp [8] = '{8'h00, 8'h8A, 8'h01, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            rd(3'(i), rdv);
            chk(rdv, exp[i], "reset value");
        end
        // Reset code 1010 in the second register turns the watchdog off
        chk({7'h0, watchdog_enable_o}, 8'h00, "wdt at reset");
        chk({4'h0, timebase_exp_o}, 8'h0A, "tb at reset");
        chk({7'h0, slow_xtal_low_power_o}, 8'h00, "lp at reset");
    endtask : t_reset

    // First control register fields and pin routing
    task automatic t_ctrl_a();
        wr(ADDR_CTRL_A, 8'h01);
        settle();
        chk({6'h0, sysclk_slow_o, fast_rc_stop_o}, 8'h03, "slow");
        wr(ADDR_CTRL_A, 8'h03);
        settle();
        chk({7'h0, slow_xtal_low_power_o}, 8'h01, "low power");
        cfg_rc_xtal_i <= 1'b0;
        settle();
        chk({6'h0, sysclk_slow_o, slow_xtal_low_power_o}, 8'h00, "opt");
        wr(ADDR_CTRL_A, 8'h7C);
        port_a_i <= 8'h04;
        port_b4_i <= 1'b0;
        divider_i <= 1'b1;
        settle();
        chk({7'h0, divider_clock_src_o}, 8'h01, "div src");
        chk({7'h0, pwm_split_o}, 8'h01, "split");
        chk({5'h0, pwm_out_en_o}, 8'h03, "pwm en");
        chk({7'h0, tp_clk_from_sys_o}, 8'h01, "tp clk");
        chk({6'h0, div_on_pa1_o, div_on_pb3_o}, 8'h02, "div pa1");
        chk({7'h0, timer0_input_o}, 8'h01, "t0 on pa2");
        wr(ADDR_CTRL_A, 8'h84);
        settle();
        chk({6'h0, div_on_pa1_o, div_on_pb3_o}, 8'h01, "div pb3");
        chk({7'h0, timer0_input_o}, 8'h00, "t0 on pb4");
        chk({7'h0, tp_clk_from_sys_o}, 8'h00, "tp idle");
        rd(ADDR_CTRL_A, rdv);
        chk(rdv, 8'h84, "ctrl a read");
        cfg_rc_xtal_i <= 1'b1;
    endtask : t_ctrl_a

    // Trigger modes, time base and watchdog code
    task automatic t_ctrl_b();
        int exp [4] = '{0, 1, 1, 2};
        wr(ADDR_CTRL_A, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_CTRL_B, {2'(m), 6'h05});
            settle();
            irq_cnt = 0;
            port_a_i[3] <= 1'b1;
            repeat (8) @(posedge mclk_i);
            port_a_i[3] <= 1'b0;
            settle();
            repeat (6) @(posedge mclk_i);
            chk(8'(irq_cnt), 8'(exp[m]), "edge mode");
        end
        wr(ADDR_CTRL_A, 8'h80);
        settle();
        irq_cnt = 0;
        port_b5_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        port_b5_i <= 1'b0;
        settle();
        repeat (6) @(posedge mclk_i);
        chk(8'(irq_cnt), 8'h02, "irq on pb5");
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CTRL_B, {2'b00, 2'(c), 4'h5});
            settle();
            chk({4'h0, timebase_exp_o}, 8'(10 + c), "tb exp");
        end
        wr(ADDR_CTRL_B, 8'h0A);
        settle();
        chk({7'h0, watchdog_enable_o}, 8'h00, "wdt off");
        cfg_wdt_on_i <= 1'b1;
        settle();
        chk({7'h0, watchdog_enable_o}, 8'h01, "wdt forced");
        cfg_wdt_on_i <= 1'b0;
        wr(ADDR_CTRL_B, 8'h0B);
        settle();
        chk({7'h0, watchdog_enable_o}, 8'h01, "wdt other");
    endtask : t_ctrl_b

    // Third register, halt behaviour
    task automatic t_ctrl_c();
        wr(ADDR_CTRL_C, 8'hFF);
        rd(ADDR_CTRL_C, rdv);
        chk(rdv, 8'h11, "ctrl c read");
        halt_i <= 1'b1;
        settle();
        chk({5'h0, pwm_out_en_o}, 8'h04, "pwm2");
        chk({7'h0, slow_xtal_run_o}, 8'h01, "keep xtal");
        chk({6'h0, fast_clk_run_o, fast_rc_stop_o}, 8'h01, "halt");
        wr(ADDR_CTRL_C, 8'h00);
        settle();
        chk({7'h0, slow_xtal_run_o}, 8'h00, "stop xtal");
        halt_i <= 1'b0;
        settle();
        chk({6'h0, fast_clk_run_o, fast_rc_stop_o}, 8'h02, "run");
    endtask : t_ctrl_c

    // Wake, pull-high, LCD commons, oscillator pins, unmapped
    task automatic t_aux();
        wr(ADDR_WAKE, 8'h01);
        halt_i <= 1'b1;
        port_a_i <= 8'h03;
        settle();
        wake_cnt = 0;
        port_a_i <= 8'h00;
        settle();
        repeat (4) @(posedge mclk_i);
        chk(8'(wake_cnt), 8'h01, "wake");
        halt_i <= 1'b0;
        port_a_dir_in_i <= 8'h0F;
        port_b_dir_in_i <= 8'hF0;
        cfg_ext_rc_i <= 1'b1;
        wr(ADDR_PULL_A, 8'hFF);
        wr(ADDR_PULL_B, 8'h3C);
        wr(ADDR_LCD_COM, 8'h05);
        wr(3'h7, 8'hFF);
        settle();
        chk(pull_a_o, 8'h0F, "pull a");
        chk(pull_b_o, 8'h30, "pull b");
        chk({4'h0, lcd_com_en_o}, 8'h05, "lcd");
        chk({6'h0, pa6_osc_o, pa5_io_free_o}, 8'h03, "ext rc");
        rd(3'h7, rdv);
        chk(rdv, 8'h00, "unmapped");
        rd(ADDR_LCD_COM, rdv);
        chk(rdv, 8'h05, "lcd read");
    endtask : t_aux

    // Main sequence
    initial
    begin
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_ctrl_a();
        t_ctrl_b();
        t_ctrl_c();
        t_aux();
        give_verdict();
    end
endmodule : tb_scr_control_regs
`default_nettype wire
